// >>> pkg/oms_pkg.sv
// Behaviour
// [RULE1] supply_valid low keeps the controller inactive in idle mode.
// [RULE2] supply valid, off and no adapter gives off mode; key stays watched.
// [RULE3] adapter present or switched on launches the boot program.
// [RULE4] no valid firmware keeps boot mode until switched off or unpowered.
// [RULE5] up and right keys held at switch-on force boot mode.
// [RULE6] firmware valid, adapter, off: charge mode, flyback off, charger on.
// [RULE7] firmware valid, adapter, on: flyback on, charger on.
// [RULE8] firmware valid, battery only, on: flyback on, charger off.
// [RULE9] battery low while flyback starts drops back to off mode; with adapter present the code enters charge mode.
// [RULE10] refresh due after fifty partial cycles or six months.
// [RULE11] refresh due whenever the battery has been removed.
// [RULE12] due refresh prompts the user after the start-up screen.
// [RULE13] refresh starts only while switched on with adapter present.
// [RULE14] refresh is charge, discharge on battery, charge; at most 16 h.
// [RULE15] on/off key logic sits outside the matrix, alive while off.
// [RULE16] while off, charging and the key stay under control.
// [RULE17] flyback enabled only while switched on.
// [RULE18] every on/off key press toggles one on/off status bit.
// [RULE19] supply_valid low resets the whole controller.
// [RULE20] mode re-evaluated every clock, exactly one mode at a time.
package oms_pkg;
  localparam longint CLK_HZ           = 100_000_000;
  // register map
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STAT    = 8'h04;
  localparam logic [7:0] ADDR_PCNT    = 8'h08;
  localparam int CTRL_START           = 0;
  localparam int CTRL_ABORT           = 1;
  localparam int CTRL_CLR_DUE         = 2;
  // refresh bookkeeping
  localparam logic [5:0] PARTIAL_LIMIT = 6'h32;
  localparam longint AGE_MONTHS       = 6;
  localparam longint DAYS_PER_MONTH   = 30;
  localparam longint REFRESH_MAX_H    = 16;
  localparam longint FLY_START_US     = 1000;
  localparam longint AGE_CYC = AGE_MONTHS * DAYS_PER_MONTH * 86400 * CLK_HZ;
  localparam longint REFRESH_MAX_CYC = REFRESH_MAX_H * 3600 * CLK_HZ;
  localparam longint FLY_START_CYC = FLY_START_US * CLK_HZ / 1_000_000;
  // values after reset
  localparam logic ON_RST             = 1'b0;
  localparam logic DUE_RST            = 1'b0;
  typedef enum logic [2:0] {
    M_IDLE, M_OFF, M_BOOT, M_CHARGE, M_OPCHG, M_OPER
  } oms_mode_e;
  typedef enum logic [1:0] {
    RF_IDLE, RF_CHG1, RF_DIS, RF_CHG2
  } oms_phase_e;
endpackage : oms_pkg

// >>> pkg/oms_ref_if.sv
`timescale 1ns/1ps
`default_nettype none
interface oms_ref_if;
  import oms_pkg::*;
  logic       start;
  logic       abort;
  logic       clr_due;
  logic       allowed;
  logic       due;
  oms_phase_e phase;
  logic [5:0] pcount;
  modport ctl (output start, abort, clr_due, allowed,
               input due, phase, pcount);
  modport refr (input start, abort, clr_due, allowed,
                output due, phase, pcount);
endinterface : oms_ref_if
`default_nettype wire

// >>> tb/oms_partner.sv
`timescale 1ns/1ps
`default_nettype none
module oms_partner (
  input  wire logic        core_clk,      // controller clock
  input  wire logic        nrst,          // async reset, active low
  input  wire logic [15:0] rail_mv,       // backup rail level in mV
  input  wire logic [15:0] batt_mv,       // battery level in mV
  input  wire logic [15:0] adapter_mv,    // adapter level in mV
  input  wire logic        press,         // pulse: user presses the key
  output logic             supply_valid,  // backup rail good
  output logic             adapter_valid, // adapter good
  output logic             batt_low,      // battery below low limit
  output logic             onoff_key      // key contact, high pressed
);
  logic [2:0] hold; // cycles the key stays down

  // rail comparators and key contact, as the power chip reports them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      supply_valid  <= 1'b0;
      adapter_valid <= 1'b0;
      batt_low      <= 1'b0;
      onoff_key     <= 1'b0;
      hold          <= 3'h0;
    end else begin
      supply_valid  <= (rail_mv > 16'h0BEA);     // above 3.05 V
      adapter_valid <= (adapter_mv >= 16'h2710); // at least 10 V
      batt_low      <= (batt_mv < 16'h0FA0);     // below 4 V
      onoff_key     <= (hold != 3'h0);           // bounce-free press
      if (press)
        hold <= 3'h4;
      else if (hold != 3'h0)
        hold <= hold - 3'h1;
    end
  end
endmodule : oms_partner
`default_nettype wire

// >>> tb/test_operating_mode_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_operating_mode_sequencer;
  import oms_pkg::*;
  logic        core_clk, nrst, press, key_up, key_right, fw_valid;
  logic        startup_done, cycle_done, batt_present, batt_full;
  logic        batt_empty, wr, rd, supply_valid, adapter_valid;
  logic        batt_low, onoff_key, flyback_en, charger_en;
  logic        refresh_due, refresh_active, refresh_prompt;
  logic [15:0] rail_mv, batt_mv, adapter_mv;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  oms_mode_e   mode;
  int          failures, tests_run, cycles, n;

  oms_partner partner_u (.core_clk(core_clk), .nrst(nrst),
    .rail_mv(rail_mv), .batt_mv(batt_mv), .adapter_mv(adapter_mv),
    .press(press), .supply_valid(supply_valid),
    .adapter_valid(adapter_valid), .batt_low(batt_low),
    .onoff_key(onoff_key));

  oms_top #(.AGE_CYC(64'h3E8), .MAX_CYC(64'h1F4), .FLY_CYC(32'h14)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .supply_valid(supply_valid),
    .adapter_valid(adapter_valid), .onoff_key(onoff_key),
    .key_up(key_up), .key_right(key_right), .fw_valid(fw_valid),
    .batt_low(batt_low), .startup_done(startup_done),
    .cycle_done(cycle_done), .batt_present(batt_present),
    .batt_full(batt_full), .batt_empty(batt_empty), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .mode(mode),
    .flyback_en(flyback_en), .charger_en(charger_en),
    .refresh_due(refresh_due), .refresh_active(refresh_active),
    .refresh_prompt(refresh_prompt));

  // mode expected from switch-on state and adapter, firmware valid
  function automatic oms_mode_e exp_mode(input logic on, input logic adp);
    if (on)
      return adp ? M_OPCHG : M_OPER;
    return adp ? M_CHARGE : M_OFF;
  endfunction : exp_mode

  task automatic finish_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic out(input oms_mode_e m, input logic f, input logic c);
    chk("mode", 32'(m), 32'(mode));
    chk("flyback_en", 32'(f), 32'(flyback_en));
    chk("charger_en", 32'(c), 32'(charger_en));
  endtask : out

  // flyback follows switch-on, charger follows adapter
  task automatic op(input logic on, input logic adp);
    out(exp_mode(on, adp), on, adp);
  endtask : op

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : step

  // one register access; read data land in d
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    @(posedge core_clk);
    addr  <= a;
    wdata <= v;
    wr    <= w;
    rd    <= !w;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus

  task automatic key(input int k);
    @(posedge core_clk);
    press <= 1'b1;
    @(posedge core_clk);
    press <= 1'b0;
    step(k);
  endtask : key

  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge core_clk);
      cycle_done <= 1'b1;
      @(posedge core_clk);
      cycle_done <= 1'b0;
    end
    step(2);
  endtask : pulses

  task automatic fe(input logic f, input logic e);
    @(posedge core_clk);
    batt_full  <= f;
    batt_empty <= e;
    @(posedge core_clk);
    batt_full  <= 1'b0;
    batt_empty <= 1'b0;
    step(3);
  endtask : fe

  task automatic phase(input logic [1:0] p, input logic c);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("phase", 32'(p), 32'(d[9:8]));
    chk("charger_en", 32'(c), 32'(charger_en));
  endtask : phase

  // free-running clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      finish_test();
    end
  end

  // main sequence
  initial begin
    {nrst, press, key_up, key_right, startup_done, cycle_done} = '0;
    {batt_full, batt_empty, wr, rd, addr, wdata} = '0;
    {fw_valid, batt_present} = 2'h3;
    rail_mv = 16'h0;
    batt_mv = 16'h12C0;
    adapter_mv = 16'h0;
    n = $urandom(24864);
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    step(3);
    out(M_IDLE, 1'b0, 1'b0);
    @(posedge core_clk);
    rail_mv <= 16'h0CE4;
    step(4);
    op(1'b0, 1'b0);
    key(6);
    op(1'b1, 1'b0);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk("stat_on", 32'h1, 32'(d[3]));
    bus(1'b1, ADDR_CTRL, 32'h1);
    step(3);
    chk("refresh_active", 32'h0, 32'(refresh_active));
    key(6);
    op(1'b0, 1'b0);
    @(posedge core_clk);
    adapter_mv <= 16'($urandom_range(15000, 10000));
    step(4);
    op(1'b0, 1'b1);
    key(6);
    op(1'b1, 1'b1);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, d);
    @(posedge core_clk);
    batt_present <= 1'b0;
    step(3);
    chk("refresh_due", 32'h1, 32'(refresh_due));
    @(posedge core_clk);
    batt_present <= 1'b1;
    bus(1'b1, ADDR_CTRL, 32'h4);
    step(2);
    chk("refresh_due", 32'h0, 32'(refresh_due));
    n = $urandom_range(48, 1);
    pulses(n);
    bus(1'b0, ADDR_PCNT, 32'h0);
    chk("partial_count", 32'(n), {26'h0, d[5:0]});
    pulses(49 - n);
    chk("refresh_due", 32'h0, 32'(refresh_due));
    pulses(1);
    chk("refresh_due", 32'h1, 32'(refresh_due));
    @(posedge core_clk);
    startup_done <= 1'b1;
    @(posedge core_clk);
    startup_done <= 1'b0;
    #1;
    chk("refresh_prompt", 32'h1, 32'(refresh_prompt));
    step(1);
    chk("refresh_prompt", 32'h0, 32'(refresh_prompt));
    bus(1'b1, ADDR_CTRL, 32'h1);
    step(3);
    chk("refresh_active", 32'h1, 32'(refresh_active));
    phase(2'h1, 1'b1);
    fe(1'b1, 1'b0);
    phase(2'h2, 1'b0);
    fe(1'b0, 1'b1);
    phase(2'h3, 1'b1);
    fe(1'b1, 1'b0);
    chk("refresh_active", 32'h0, 32'(refresh_active));
    chk("refresh_due", 32'h0, 32'(refresh_due));
    step(900);
    chk("refresh_due", 32'h0, 32'(refresh_due));
    step(120);
    chk("refresh_due", 32'h1, 32'(refresh_due));
    bus(1'b1, ADDR_CTRL, 32'h1);
    step(400);
    chk("refresh_active", 32'h1, 32'(refresh_active));
    step(110);
    chk("refresh_active", 32'h0, 32'(refresh_active));
    bus(1'b1, ADDR_CTRL, 32'h1);
    step(3);
    chk("refresh_active", 32'h1, 32'(refresh_active));
    bus(1'b1, ADDR_CTRL, 32'h2);
    step(3);
    chk("refresh_active", 32'h0, 32'(refresh_active));
    key(6);
    op(1'b0, 1'b1);
    @(posedge core_clk);
    fw_valid <= 1'b0;
    step(4);
    chk("mode", 32'(M_BOOT), 32'(mode));
    @(posedge core_clk);
    fw_valid <= 1'b1;
    step(4);
    chk("mode", 32'(M_BOOT), 32'(mode));
    @(posedge core_clk);
    adapter_mv <= 16'h0;
    step(4);
    op(1'b0, 1'b0);
    @(posedge core_clk);
    key_up    <= 1'b1;
    key_right <= 1'b1;
    key(6);
    chk("mode", 32'(M_BOOT), 32'(mode));
    @(posedge core_clk);
    key_up    <= 1'b0;
    key_right <= 1'b0;
    key(6);
    op(1'b0, 1'b0);
    @(posedge core_clk);
    batt_mv <= 16'h0ED8;
    key(10);
    op(1'b0, 1'b0);
    @(posedge core_clk);
    batt_mv <= 16'($urandom_range(5200, 4200));
    key(6);
    op(1'b1, 1'b0);
    @(posedge core_clk);
    rail_mv <= 16'h0B54;
    step(4);
    out(M_IDLE, 1'b0, 1'b0);
    chk("refresh_due", 32'h0, 32'(refresh_due));
    @(posedge core_clk);
    rail_mv <= 16'h0CE4;
    step(4);
    op(1'b0, 1'b0);
    finish_test();
  end
endmodule : test_operating_mode_sequencer
`default_nettype wire

// >>> verilog/oms_onoff.sv
`timescale 1ns/1ps
`default_nettype none
module oms_onoff (
  input  wire logic core_clk,     // controller clock
  input  wire logic nrst,         // async reset, active low
  input  wire logic supply_valid, // low clears the status bit
  input  wire logic key,          // on/off key, high while pressed
  input  wire logic force_off,    // clears the status bit
  output logic      on            // on/off status bit
);
  import oms_pkg::*;
  typedef struct packed {
    logic key_d;
    logic on;
  } oms_key_s;
  oms_key_s s, next_s;

  // dedicated key edge logic, runs in every mode except idle [RULE15]
  always_comb begin
    next_s = s;
    next_s.key_d = key;
    if (!supply_valid) begin
      next_s = '{key_d: 1'b0, on: ON_RST}; // [RULE19]
    end else if (force_off) begin
      next_s.on = 1'b0;
    end else if (key && !s.key_d) begin
      next_s.on = !s.on; // [RULE18]
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) s <= '{key_d: 1'b0, on: ON_RST};
    else s <= next_s;
  end

  assign on = s.on;

  AST_TOGGLE: assert property (@(posedge core_clk) disable iff (!nrst)
    supply_valid && key && !s.key_d && !force_off |=> on != $past(on)) // [RULE18]
    else $error("key press did not toggle the status bit");
endmodule : oms_onoff
`default_nettype wire

// >>> verilog/oms_refresh.sv
`timescale 1ns/1ps
`default_nettype none
module oms_refresh #(
  parameter logic [63:0] AGE_CYC = 64'(oms_pkg::AGE_CYC),
  parameter logic [63:0] MAX_CYC = 64'(oms_pkg::REFRESH_MAX_CYC)
) (
  input  wire logic core_clk,     // controller clock
  input  wire logic nrst,         // async reset, active low
  input  wire logic supply_valid, // low clears all state
  input  wire logic cycle_done,   // pulse: partial charge cycle ended
  input  wire logic batt_present, // battery installed
  input  wire logic batt_full,    // battery fully charged
  input  wire logic batt_empty,   // battery fully discharged
  oms_ref_if.refr   rf            // link to the mode logic
);
  import oms_pkg::*;
  typedef struct packed {
    logic [5:0]  pcount;
    logic [63:0] age;
    logic [63:0] rtime;
    oms_phase_e  phase;
    logic        due;
    logic        pres_d;
  } oms_ref_s;
  oms_ref_s s, next_s;
  localparam oms_ref_s REF_RST = '{6'h00, 64'h0, 64'h0, RF_IDLE, DUE_RST,
                                   1'b0};

  // counters and refresh phases; clears first so that sets win
  always_comb begin
    next_s = s;
    next_s.pres_d = batt_present;
    if (rf.clr_due) next_s.due = 1'b0;
    if (s.age != AGE_CYC) next_s.age = s.age + 64'h1;
    if (s.phase != RF_IDLE) begin
      next_s.rtime = s.rtime + 64'h1;
      if (rf.abort || !rf.allowed || s.rtime >= MAX_CYC - 64'h1) begin
        next_s.phase = RF_IDLE; // [RULE13] [RULE14]
      end else begin
        case (s.phase)
          RF_CHG1: if (batt_full) next_s.phase = RF_DIS;
          RF_DIS:  if (batt_empty) next_s.phase = RF_CHG2;
          RF_CHG2: if (batt_full) begin
            next_s.phase = RF_IDLE; // [RULE14]
            next_s.due = 1'b0;
            next_s.pcount = 6'h00;
            next_s.age = 64'h0;
          end
          default: next_s.phase = RF_IDLE;
        endcase
      end
    end else if (rf.start && rf.allowed) begin
      next_s.phase = RF_CHG1; // [RULE13]
      next_s.rtime = 64'h0;
    end
    if (cycle_done && next_s.pcount != PARTIAL_LIMIT) begin
      next_s.pcount = next_s.pcount + 6'h01; // counts on after a clear
    end
    if (next_s.pcount == PARTIAL_LIMIT || next_s.age == AGE_CYC) begin
      next_s.due = 1'b1; // [RULE10]
    end
    if (s.pres_d && !batt_present) next_s.due = 1'b1; // [RULE11]
    if (!supply_valid) next_s = REF_RST;
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) s <= REF_RST;
    else s <= next_s;
  end

  assign rf.due = s.due;
  assign rf.phase = s.phase;
  assign rf.pcount = s.pcount;

  AST_DUE_CNT: assert property (@(posedge core_clk) disable iff (!nrst)
    supply_valid && cycle_done && s.pcount == 6'h31 |=> rf.due) // [RULE10]
    else $error("fifty partial cycles did not flag refresh");
  AST_REMOVE: assert property (@(posedge core_clk) disable iff (!nrst)
    supply_valid && $fell(batt_present) |=> rf.due) // [RULE11]
    else $error("battery removal did not flag refresh");
  AST_REF_START: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(s.phase != RF_IDLE) |-> $past(rf.start && rf.allowed)) // [RULE13]
    else $error("refresh began without a permitted start");
  AST_REF_MAX: assert property (@(posedge core_clk) disable iff (!nrst)
    s.phase != RF_IDLE |-> s.rtime < MAX_CYC) // [RULE14]
    else $error("refresh ran past its time bound");
endmodule : oms_refresh
`default_nettype wire

// >>> verilog/oms_top.sv
`timescale 1ns/1ps
`default_nettype none
module oms_top #(
  parameter logic [63:0] AGE_CYC = 64'(oms_pkg::AGE_CYC),
  parameter logic [63:0] MAX_CYC = 64'(oms_pkg::REFRESH_MAX_CYC),
  parameter logic [31:0] FLY_CYC = 32'(oms_pkg::FLY_START_CYC)
) (
  input  wire logic        core_clk,       // controller clock
  input  wire logic        nrst,           // async reset, active low
  input  wire logic        supply_valid,   // backup rail good
  input  wire logic        adapter_valid,  // adapter voltage good
  input  wire logic        onoff_key,      // on/off key pressed
  input  wire logic        key_up,         // up key held
  input  wire logic        key_right,      // right key held
  input  wire logic        fw_valid,       // firmware check passed
  input  wire logic        batt_low,       // battery below low limit
  input  wire logic        startup_done,   // pulse: start-up screen over
  input  wire logic        cycle_done,     // pulse: partial cycle ended
  input  wire logic        batt_present,   // battery installed
  input  wire logic        batt_full,      // battery full
  input  wire logic        batt_empty,     // battery empty
  input  wire logic [7:0]  addr,           // register address
  input  wire logic [31:0] wdata,          // write data
  input  wire logic        wr,             // write strobe
  input  wire logic        rd,             // read strobe
  output logic      [31:0] rdata,          // read data, cycle after rd
  output oms_pkg::oms_mode_e mode,         // operating mode
  output logic             flyback_en,     // flyback converter enable
  output logic             charger_en,     // charger converter enable
  output logic             refresh_due,    // refresh needed
  output logic             refresh_active, // refresh running
  output logic             refresh_prompt  // pulse: ask user
);
  import oms_pkg::*;

  typedef struct packed {
    oms_mode_e   mode;
    logic        fly;
    logic        chg;
    logic        boot_lock;
    logic        boot_force;
    logic        on_d;
    logic [31:0] fly_tmr;
    logic        prompt;
    logic        due_q;
    logic        act_q;
    logic [31:0] rdata;
    logic        start;
    logic        abort;
    logic        clr;
  } oms_top_s;

  localparam oms_top_s TOP_RST = '{
    mode: M_IDLE, fly: 1'b0, chg: 1'b0, boot_lock: 1'b0,
    boot_force: 1'b0, on_d: ON_RST, fly_tmr: 32'h0, prompt: 1'b0,
    due_q: DUE_RST, act_q: 1'b0, rdata: 32'h0, start: 1'b0,
    abort: 1'b0, clr: 1'b0
  };

  oms_top_s s, next_s;
  logic     on;
  logic     force_off;
  logic     run;
  logic     fly_win;

  oms_ref_if rif ();

  // key status bit, kept alive in every mode except idle
  oms_onoff u_onoff (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .supply_valid (supply_valid),
    .key          (onoff_key),
    .force_off    (force_off),
    .on           (on)
  );

  // refresh counters and phase sequencing
  oms_refresh #(
    .AGE_CYC (AGE_CYC),
    .MAX_CYC (MAX_CYC)
  ) u_refresh (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .supply_valid (supply_valid),
    .cycle_done   (cycle_done),
    .batt_present (batt_present),
    .batt_full    (batt_full),
    .batt_empty   (batt_empty),
    .rf           (rif.ctl)
  );

  // boot program runs whenever adapter or switch-on asks for it
  assign run = on || adapter_valid; // [RULE3]

  // flyback start window and low battery fall-back
  assign fly_win = s.fly && (s.fly_tmr != 32'h0);
  assign force_off = fly_win && batt_low; // [RULE9]

  // refresh may only run in operational and charge mode
  assign rif.allowed = on && adapter_valid && s.mode == M_OPCHG; // [RULE13]
  assign rif.start = s.start;
  assign rif.abort = s.abort;
  assign rif.clr_due = s.clr;

  // mode choice, re-evaluated every clock
  always_comb begin
    next_s = s;
    next_s.on_d = on;
    next_s.start = 1'b0;
    next_s.abort = 1'b0;
    next_s.clr = 1'b0;
    next_s.rdata = 32'h0;
    next_s.due_q = rif.due;
    next_s.act_q = rif.phase != RF_IDLE;

    // boot latches follow switch-on and power
    if (!run) begin
      next_s.boot_lock = 1'b0; // [RULE4]
      next_s.boot_force = 1'b0;
    end else begin
      if (s.on_d && !on) begin
        next_s.boot_lock = 1'b0; // [RULE4]
        next_s.boot_force = 1'b0;
      end
      if (on && !s.on_d) begin
        next_s.boot_force = key_up && key_right; // [RULE5]
      end
      if (!fw_valid) next_s.boot_lock = 1'b1; // [RULE4]
    end

    // one mode at a time [RULE20]
    if (!run) begin
      next_s.mode = M_OFF; // [RULE2] [RULE16]
    end else if (next_s.boot_lock || next_s.boot_force) begin
      next_s.mode = M_BOOT; // [RULE3]
    end else if (adapter_valid && !on) begin
      next_s.mode = M_CHARGE; // [RULE6]
    end else if (adapter_valid) begin
      next_s.mode = M_OPCHG; // [RULE7]
    end else begin
      next_s.mode = M_OPER; // [RULE8]
    end

    // converter enables from the chosen mode
    case (next_s.mode)
      M_CHARGE: begin
        next_s.fly = 1'b0; // [RULE6]
        next_s.chg = 1'b1; // [RULE16]
      end
      M_OPCHG: begin
        next_s.fly = 1'b1; // [RULE7] [RULE17]
        next_s.chg = rif.phase != RF_DIS; // [RULE14]
      end
      M_OPER: begin
        next_s.fly = 1'b1; // [RULE8] [RULE17]
        next_s.chg = 1'b0;
      end
      default: begin
        next_s.fly = 1'b0; // [RULE17]
        next_s.chg = 1'b0;
      end
    endcase

    // start window counts down after each flyback turn-on
    if (next_s.fly && !s.fly) begin
      next_s.fly_tmr = FLY_CYC;
    end else if (!next_s.fly) begin
      next_s.fly_tmr = 32'h0;
    end else if (s.fly_tmr != 32'h0) begin
      next_s.fly_tmr = s.fly_tmr - 32'h1;
    end

    // prompt right after the start-up screen when due
    next_s.prompt = startup_done && on && s.due_q; // [RULE12]

    // register writes give one-cycle commands
    if (wr && addr == ADDR_CTRL) begin
      next_s.start = wdata[CTRL_START]; // [RULE13]
      next_s.abort = wdata[CTRL_ABORT];
      next_s.clr = wdata[CTRL_CLR_DUE];
    end

    // register reads answer in the next cycle only
    if (rd) begin
      case (addr)
        ADDR_STAT: begin
          next_s.rdata = {21'h0, s.boot_lock, 2'(rif.phase),
                          s.act_q, s.due_q, s.chg, s.fly, on,
                          3'(s.mode)};
        end
        ADDR_PCNT: next_s.rdata = {26'h0, rif.pcount};
        default:   next_s.rdata = 32'h0;
      endcase
    end

    // a low supply_valid holds everything in idle
    if (!supply_valid) begin
      next_s = TOP_RST; // [RULE1] [RULE19]
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) s <= TOP_RST;
    else s <= next_s;
  end

  // outputs straight from the state register
  assign rdata = s.rdata;
  assign mode = s.mode;
  assign flyback_en = s.fly;
  assign charger_en = s.chg;
  assign refresh_due = s.due_q;
  assign refresh_active = s.act_q;
  assign refresh_prompt = s.prompt;

  // idle while the backup rail is bad
  AST_IDLE: assert property (@(posedge core_clk) disable iff (!nrst)
    !supply_valid |=> mode == M_IDLE && !flyback_en && !charger_en) // [RULE1]
    else $error("controller active with supply_valid low");

  // off mode with battery only and switched off
  AST_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
    supply_valid && !on && !adapter_valid |=> mode == M_OFF) // [RULE2]
    else $error("off mode not entered");

  // missing firmware keeps the boot program running
  AST_BOOT_NOFW: assert property (@(posedge core_clk) disable iff (!nrst)
    supply_valid && run && !fw_valid |=> mode == M_BOOT) // [RULE4]
    else $error("invalid firmware left boot mode");

  // key combination at switch-on forces boot mode
  AST_KEYBOOT: assert property (@(posedge core_clk) disable iff (!nrst)
    supply_valid && on && !s.on_d && key_up && key_right
    |=> mode == M_BOOT) // [RULE5]
    else $error("boot key combination ignored");

  // charge mode: charger on, flyback off, adapter seen
  AST_CHARGE: assert property (@(posedge core_clk) disable iff (!nrst)
    mode == M_CHARGE |-> charger_en && !flyback_en
    && $past(adapter_valid) && !$past(on)) // [RULE6]
    else $error("charge mode outputs wrong");

  // operational and charge mode
  AST_OPCHG: assert property (@(posedge core_clk) disable iff (!nrst)
    mode == M_OPCHG |-> flyback_en && $past(on)
    && $past(adapter_valid)) // [RULE7]
    else $error("operational and charge mode wrong");

  // operational mode on battery
  AST_OPER: assert property (@(posedge core_clk) disable iff (!nrst)
    mode == M_OPER |-> flyback_en && !charger_en && $past(on)
    && !$past(adapter_valid)) // [RULE8]
    else $error("operational mode wrong");

  // low battery during flyback start switches off
  AST_BATLOW: assert property (@(posedge core_clk) disable iff (!nrst)
    supply_valid && fly_win && batt_low |=> !on ##1 !flyback_en) // [RULE9]
    else $error("low battery at flyback start ignored");

  // flyback only when switched on
  AST_FLY_ON: assert property (@(posedge core_clk) disable iff (!nrst)
    flyback_en |-> $past(on)) // [RULE17]
    else $error("flyback enabled while off");

  // prompt only after start-up screen with refresh due
  AST_PROMPT: assert property (@(posedge core_clk) disable iff (!nrst)
    refresh_prompt |-> $past(startup_done) && $past(s.due_q)) // [RULE12]
    else $error("refresh prompt without cause");

  // discharge phase runs from battery only
  AST_DIS: assert property (@(posedge core_clk) disable iff (!nrst)
    $past(rif.phase) == RF_DIS && mode == M_OPCHG |-> !charger_en) // [RULE14]
    else $error("charger on during refresh discharge");
endmodule : oms_top
`default_nettype wire
